// [verilog/fss_pkg.sv]
// constants, types and field layouts for the flash security guard
// assumes a single core clock and a flash engine that obeys flash_go
// Functional notes
// - signature opens with three-byte device code
// - ten ASCII name bytes, space padded
// - code flash last address, three bytes, LSB first
// - data flash last address, LSB first, zero if absent
// - three version digits, most significant first
// - stored security applies at next mode entry
// - erase prohibition blocks external erase only
// - write prohibition blocks external writes only
// - boot prohibition guards lowest 4 KB always
// - factory state: all prohibitions clear
// - flags independent, combined enforcement
// - settings accepted externally and by self-programming
// - erase and boot prohibitions are permanent
// - write prohibition cleared only by external release
// - release needs blank code flash and flag combination
// - every command answered with ACK or NAK
package fss_pkg;

    typedef enum logic [2:0] {
        FSS_OP_ERASE,
        FSS_OP_WRITE,
        FSS_OP_SEC_SET,
        FSS_OP_SEC_RELEASE,
        FSS_OP_OTHER
    } fss_op_e;

    typedef struct packed {
        logic erase;
        logic write;
        logic boot;
    } fss_sec_s;

    typedef struct packed {
        fss_op_e  op;
        logic     self_prog;
        logic [19:0] addr;
        fss_sec_s flags;
    } fss_cmd_s;

    localparam fss_sec_s    FSS_SEC_RESET = 3'b000;
    localparam logic [19:0] FSS_BC0_LAST  = 20'h00fff;
    localparam logic        FSS_REL_ERASE = 1'b0;
    localparam logic        FSS_REL_BOOT  = 1'b0;
    localparam logic        FSS_ACK       = 1'b1;
    localparam logic        FSS_NAK       = 1'b0;
    localparam logic [7:0]  FSS_SPACE     = 8'h20;
    localparam int          FSS_CODE_LEN  = 3;
    localparam int          FSS_NAME_LEN  = 10;
    localparam int          FSS_ADDR_LEN  = 3;
    localparam int          FSS_VER_LEN   = 3;
    localparam int          FSS_OFS_NAME  = FSS_CODE_LEN;
    localparam int          FSS_OFS_CODE  = FSS_OFS_NAME + FSS_NAME_LEN;
    localparam int          FSS_OFS_DATA  = FSS_OFS_CODE + FSS_ADDR_LEN;
    localparam int          FSS_OFS_VER   = FSS_OFS_DATA + FSS_ADDR_LEN;
    localparam int          FSS_SIG_LEN   = FSS_OFS_VER + FSS_VER_LEN;
    localparam logic [4:0]  FSS_SIG_LAST  = 5'(FSS_SIG_LEN - 1);

endpackage : fss_pkg

// [verilog/fss_sig_rom.sv]
// signature byte table with registered read data
// assumes the caller steps the index from 0 to the last byte
`timescale 1ns/1ps
module fss_sig_rom #(
    parameter logic [23:0] DEV_CODE  = 24'h5a_a5_01, // arbitrary value
    parameter logic [79:0] DEV_NAME  = "SECGUARD",
    parameter int          NAME_USED = 8,
    parameter logic [23:0] CODE_LAST = 24'h007fff,
    parameter logic [23:0] DATA_LAST = 24'h000000,
    parameter logic [23:0] FW_VER    = 24'h01_02_03
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // read port
    input  wire logic       rd_en,
    input  wire logic [4:0] rd_idx,
    output logic      [7:0] rd_data
);
    import fss_pkg::*;

    logic [7:0] rom [FSS_SIG_LEN];

    // refuse names the table cannot hold
    if (NAME_USED < 1 || NAME_USED > FSS_NAME_LEN) begin : g_bad_name
        $error("name length out of range");
    end

    generate
        for (genvar i = 0; i < FSS_SIG_LEN; i++) begin : g_byte
            if (i < FSS_OFS_NAME) begin : g_code
                assign rom[i] = DEV_CODE[8*(2-i) +: 8];
            end else if (i < FSS_OFS_CODE) begin : g_name
                localparam int K = i - FSS_OFS_NAME;
                if (K < NAME_USED) begin : g_chr
                    assign rom[i] = DEV_NAME[8*(NAME_USED-1-K) +: 8];
                end else begin : g_pad
                    assign rom[i] = FSS_SPACE;
                end
            end else if (i < FSS_OFS_DATA) begin : g_cla
                assign rom[i] = CODE_LAST[8*(i-FSS_OFS_CODE) +: 8];
            end else if (i < FSS_OFS_VER) begin : g_dla
                assign rom[i] = DATA_LAST[8*(i-FSS_OFS_DATA) +: 8];
            end else begin : g_ver
                assign rom[i] = FW_VER[8*(FSS_SIG_LEN-1-i) +: 8];
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            rd_data <= rom[rd_idx];
        end
    end

endmodule : fss_sig_rom

// [verilog/fss_guard.sv]
// flash security guard and signature sender
// assumes one command per cycle and a flash engine gated by flash_go
`timescale 1ns/1ps
module fss_guard #(
    parameter logic [23:0] DEV_CODE  = 24'h5a_a5_01, // arbitrary value
    parameter logic [79:0] DEV_NAME  = "SECGUARD",
    parameter int          NAME_USED = 8,
    parameter logic [23:0] CODE_LAST = 24'h007fff,
    parameter logic [23:0] DATA_LAST = 24'h000000,
    parameter logic [23:0] FW_VER    = 24'h01_02_03
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // mode and flash state
    input  wire logic             mode_entry,
    input  wire logic             code_blank,
    // command and answer
    input  wire logic             cmd_valid,
    input  wire fss_pkg::fss_cmd_s cmd,
    output logic                  resp_valid,
    output logic                  resp_ack,
    output logic                  flash_go,
    // security state
    output fss_pkg::fss_sec_s     sec_active,
    output fss_pkg::fss_sec_s     sec_stored,
    // signature stream
    input  wire logic             sig_req,
    output logic                  sig_valid,
    output logic [7:0]            sig_byte,
    output logic                  sig_last
);
    import fss_pkg::*;

    logic       sig_busy;
    logic [4:0] sig_idx;
    logic       next_ack;
    logic       in_bc0;
    logic       ext;

    // boot cluster must fit inside code flash
    if (CODE_LAST[19:0] < FSS_BC0_LAST) begin : g_bad_size
        $error("code flash smaller than boot cluster");
    end

    assign in_bc0 = (cmd.addr <= FSS_BC0_LAST);
    assign ext    = !cmd.self_prog;

    // accept or refuse the current command
    always_comb begin
        next_ack = FSS_ACK;
        unique case (cmd.op)
            FSS_OP_ERASE: begin
                if ((ext && sec_active.erase) ||
                    (sec_active.boot && in_bc0))
                    next_ack = FSS_NAK;
            end
            FSS_OP_WRITE: begin
                if ((ext && sec_active.write) ||
                    (sec_active.boot && in_bc0))
                    next_ack = FSS_NAK;
            end
            FSS_OP_SEC_SET: next_ack = FSS_ACK;
            FSS_OP_SEC_RELEASE: begin
                if (!ext || !code_blank ||
                    sec_active.erase != FSS_REL_ERASE ||
                    sec_active.boot != FSS_REL_BOOT)
                    next_ack = FSS_NAK;
            end
            FSS_OP_OTHER: next_ack = FSS_ACK;
            default: next_ack = FSS_NAK;
        endcase
    end

    // answer every command, gate the flash engine
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            resp_valid <= 1'b0;
            resp_ack   <= FSS_NAK;
            flash_go   <= 1'b0;
        end else begin
            resp_valid <= cmd_valid;
            resp_ack   <= next_ack;
            flash_go   <= cmd_valid && (next_ack == FSS_ACK) &&
                          (cmd.op == FSS_OP_ERASE || cmd.op == FSS_OP_WRITE);
        end
    end

    // stored settings: set only adds, release clears write
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_stored <= FSS_SEC_RESET;
        end else if (cmd_valid && next_ack == FSS_ACK) begin
            if (cmd.op == FSS_OP_SEC_SET) begin
                sec_stored <= sec_stored | cmd.flags;
            end else if (cmd.op == FSS_OP_SEC_RELEASE) begin
                sec_stored.write <= 1'b0;
            end
        end
    end

    // enforced settings follow stored ones at mode entry
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_active <= FSS_SEC_RESET;
        end else if (mode_entry) begin
            sec_active <= sec_stored;
        end
    end

    // signature sequencer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sig_busy  <= 1'b0;
            sig_idx   <= 5'h00;
            sig_valid <= 1'b0;
            sig_last  <= 1'b0;
        end else begin
            sig_valid <= sig_busy;
            sig_last  <= sig_busy && (sig_idx == FSS_SIG_LAST);
            if (sig_busy) begin
                if (sig_idx == FSS_SIG_LAST) begin
                    sig_busy <= 1'b0;
                end
                sig_idx <= sig_idx + 5'h01;
            end else if (sig_req) begin
                sig_busy <= 1'b1;
                sig_idx  <= 5'h00;
            end
        end
    end

    fss_sig_rom #(
        .DEV_CODE  (DEV_CODE),
        .DEV_NAME  (DEV_NAME),
        .NAME_USED (NAME_USED),
        .CODE_LAST (CODE_LAST),
        .DATA_LAST (DATA_LAST),
        .FW_VER    (FW_VER)
    ) u_rom (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .rd_en    (sig_busy),
        .rd_idx   (sig_idx),
        .rd_data  (sig_byte)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_sig_start;
        sig_req && !sig_busy;
    endsequence

    sequence s_ext_erase;
        cmd_valid && cmd.op == FSS_OP_ERASE && !cmd.self_prog;
    endsequence

    // data flash last address, low byte first
    sequence s_data_bytes;
        sig_byte == DATA_LAST[7:0] ##1 sig_byte == DATA_LAST[15:8]
        ##1 sig_byte == DATA_LAST[23:16];
    endsequence

    a_sig_code_first: assert property (
        s_sig_start |-> ##2 sig_valid && sig_byte == DEV_CODE[23:16])
        else $error("signature does not open with device code");
    a_sig_name_pad: assert property (
        s_sig_start |-> ##14 sig_byte == 8'h20 || NAME_USED == 10)
        else $error("device name not space padded");
    a_sig_code_lsb: assert property (
        s_sig_start |-> ##15 sig_byte == CODE_LAST[7:0])
        else $error("code last address not LSB first");
    a_sig_ver_end: assert property (
        s_sig_start |-> ##23 sig_last && sig_byte == FW_VER[7:0]
                        ##1 !sig_valid)
        else $error("signature does not end with version");
    a_entry_apply: assert property (
        mode_entry |=> sec_active == $past(sec_stored))
        else $error("stored security not applied at entry");
    a_active_hold: assert property (
        !mode_entry |=> $stable(sec_active))
        else $error("security changed outside mode entry");
    a_ext_erase_nak: assert property (
        s_ext_erase and sec_active.erase |=> resp_valid && !resp_ack)
        else $error("external erase not refused");
    a_wp_erase_ok: assert property (
        s_ext_erase and sec_active == 3'b010 |=> resp_ack && flash_go)
        else $error("write prohibition blocked erase");
    a_ext_write_nak: assert property (
        cmd_valid && cmd.op == FSS_OP_WRITE && !cmd.self_prog &&
        sec_active.write |=> !resp_ack && !flash_go)
        else $error("external write not refused");
    a_boot_guard: assert property (
        cmd_valid && (cmd.op == FSS_OP_ERASE || cmd.op == FSS_OP_WRITE) &&
        sec_active.boot && cmd.addr < 20'h01000 |=> !flash_go)
        else $error("boot cluster rewritten");
    a_perm_flags: assert property (
        sec_stored.erase || sec_stored.boot |=>
        (sec_stored.erase >= $past(sec_stored.erase)) &&
        (sec_stored.boot >= $past(sec_stored.boot)))
        else $error("permanent prohibition cleared");
    a_self_no_release: assert property (
        cmd_valid && cmd.op == FSS_OP_SEC_RELEASE && cmd.self_prog
        |=> !resp_ack && sec_stored.write == $past(sec_stored.write))
        else $error("self-programming released write guard");
    a_release_blank: assert property (
        cmd_valid && cmd.op == FSS_OP_SEC_RELEASE && !code_blank |=> !resp_ack)
        else $error("release honoured on written flash");
    a_answer_each: assert property (
        cmd_valid |=> resp_valid ##1 !resp_valid || $past(cmd_valid))
        else $error("command left unanswered");
    a_nak_no_go: assert property (
        resp_valid && !resp_ack |-> !flash_go)
        else $error("refused command reached flash");
    a_sig_data_lsb: assert property (
        s_sig_start |-> ##18 s_data_bytes)
        else $error("data last address not LSB first");
    a_set_adds: assert property (
        cmd_valid && cmd.op == FSS_OP_SEC_SET |=> resp_valid && resp_ack &&
        !flash_go && (sec_stored & $past(cmd.flags)) == $past(cmd.flags))
        else $error("security setting not stored");
    a_release_ok: assert property (
        cmd_valid && cmd.op == FSS_OP_SEC_RELEASE && !cmd.self_prog &&
        code_blank && sec_active.erase == FSS_REL_ERASE &&
        sec_active.boot == FSS_REL_BOOT |=> resp_ack && !sec_stored.write)
        else $error("permitted release refused");

endmodule : fss_guard

// [testbench/fss_host.sv]
// host-side model: a programmer issuing commands to the guard
// assumes the answer stands one cycle after the command is taken
`timescale 1ns/1ps
module fss_host (
    // clock
    input  wire logic         core_clk,
    // answer from the guard
    input  wire logic         resp_valid,
    input  wire logic         resp_ack,
    input  wire logic         flash_go,
    // command to the guard
    output logic              cmd_valid,
    output fss_pkg::fss_cmd_s cmd
);
    import fss_pkg::*;

    initial begin
        cmd_valid = 1'b0;
        cmd       = '0;
    end

    // writes aim only at addresses not yet written in this run
    task automatic xfer(input fss_cmd_s c, input bit b2b,
                        output logic [2:0] ans);
        if (!b2b) @(posedge core_clk);
        cmd       <= c;
        cmd_valid <= 1'b1;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        #1 ans = {resp_valid, resp_ack, flash_go};
    endtask : xfer

endmodule : fss_host

// [testbench/tb.sv]
// self-checking bench for the flash security guard
// assumes default guard parameters and a host model driving commands
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
    $display("mismatch at %0t got %h exp %h", $time, (a), (e)); end end
module tb;
    import fss_pkg::*;

    typedef struct packed {
        fss_op_e     op;
        logic        sp;
        logic [19:0] addr;
        logic        ack;
    } fss_row_s;

    logic              core_clk;
    logic              rst_n;
    logic              mode_entry;
    logic              code_blank;
    logic              cmd_valid;
    fss_cmd_s          cmd;
    logic              resp_valid;
    logic              resp_ack;
    logic              flash_go;
    fss_sec_s          sec_active;
    fss_sec_s          sec_stored;
    logic              sig_req;
    logic              sig_valid;
    logic [7:0]        sig_byte;
    logic              sig_last;
    logic [2:0]        ans;
    int                mismatches = 0;
    int                tests_run  = 0;
    int                n;
    // expected stream: code, padded name, code/data last LSB first, version
    localparam logic [175:0] SIG_EXP = {24'h5aa501, "SECGUARD  ",
        24'hff7f00, 24'h000000, 24'h010203};
    fss_row_s rows[8] = '{
        '{FSS_OP_ERASE,       1'b0, 20'h02000, 1'b1},
        '{FSS_OP_WRITE,       1'b0, 20'h00100, 1'b1},
        '{FSS_OP_ERASE,       1'b1, 20'h00000, 1'b1},
        '{FSS_OP_WRITE,       1'b1, 20'h03000, 1'b1},
        '{FSS_OP_OTHER,       1'b0, 20'h00000, 1'b1},
        '{FSS_OP_SEC_RELEASE, 1'b0, 20'h00000, 1'b1},
        '{fss_op_e'(3'h5),    1'b0, 20'h00000, 1'b0},
        '{fss_op_e'(3'h7),    1'b0, 20'h00000, 1'b0}};

    fss_guard fss_guard_i (.core_clk(core_clk), .rst_n(rst_n),
        .mode_entry(mode_entry), .code_blank(code_blank),
        .cmd_valid(cmd_valid), .cmd(cmd), .resp_valid(resp_valid),
        .resp_ack(resp_ack), .flash_go(flash_go),
        .sec_active(sec_active), .sec_stored(sec_stored),
        .sig_req(sig_req), .sig_valid(sig_valid), .sig_byte(sig_byte),
        .sig_last(sig_last));

    fss_host fss_host_i (.core_clk(core_clk), .resp_valid(resp_valid),
        .resp_ack(resp_ack), .flash_go(flash_go),
        .cmd_valid(cmd_valid), .cmd(cmd));

    task automatic send(input fss_op_e op, input logic sp,
                        input logic [19:0] a, input fss_sec_s f,
                        input bit b2b, input logic ack);
        logic go;
        go = ack && (op == FSS_OP_ERASE || op == FSS_OP_WRITE);
        fss_host_i.xfer(fss_cmd_s'{op, sp, a, f}, b2b, ans);
        `CHK(ans, {1'b1, ack, go})
    endtask : send

    task automatic enter;
        @(posedge core_clk);
        mode_entry <= 1'b1;
        @(posedge core_clk);
        mode_entry <= 1'b0;
        #1;
    endtask : enter

    task end_of_test;
        if (mismatches == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // run needs about 85 cycles; allow far more
    initial begin
        #50000;
        mismatches++;
        end_of_test;
    end

    initial begin
        rst_n      = 1'b0;
        mode_entry = 1'b0;
        code_blank = 1'b1;
        sig_req    = 1'b0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        #1 `CHK({sec_active, sec_stored}, 6'h00)
        foreach (rows[i]) begin
            send(rows[i].op, rows[i].sp, rows[i].addr, 3'h0, 0, rows[i].ack);
        end
        send(FSS_OP_SEC_SET, 1'b0, 20'h0, 3'h2, 0, 1'b1);
        `CHK(sec_stored, 3'h2)
        send(FSS_OP_WRITE, 1'b0, 20'h04000, 3'h0, 0, 1'b1);
        `CHK(sec_active, 3'h0)
        enter;
        `CHK(sec_active, 3'h2)
        send(FSS_OP_WRITE, 1'b0, 20'h05000, 3'h0, 0, 1'b0);
        send(FSS_OP_ERASE, 1'b0, 20'h05000, 3'h0, 1, 1'b1);
        send(FSS_OP_WRITE, 1'b1, 20'h06000, 3'h0, 1, 1'b1);
        send(FSS_OP_SEC_RELEASE, 1'b1, 20'h0, 3'h0, 1, 1'b0);
        @(posedge core_clk) code_blank <= 1'b0;
        send(FSS_OP_SEC_RELEASE, 1'b0, 20'h0, 3'h0, 0, 1'b0);
        @(posedge core_clk) code_blank <= 1'b1;
        send(FSS_OP_SEC_RELEASE, 1'b0, 20'h0, 3'h0, 0, 1'b1);
        `CHK(sec_stored, 3'h0)
        send(FSS_OP_SEC_SET, 1'b1, 20'h0, 3'h5, 0, 1'b1);
        enter;
        `CHK(sec_active, 3'h5)
        send(FSS_OP_ERASE, 1'b0, 20'h02000, 3'h0, 0, 1'b0);
        send(FSS_OP_ERASE, 1'b1, 20'h02000, 3'h0, 1, 1'b1);
        send(FSS_OP_ERASE, 1'b1, 20'h00fff, 3'h0, 1, 1'b0);
        send(FSS_OP_WRITE, 1'b1, 20'h01000, 3'h0, 1, 1'b1);
        send(FSS_OP_WRITE, 1'b0, 20'h00000, 3'h0, 1, 1'b0);
        send(FSS_OP_WRITE, 1'b0, 20'h07000, 3'h0, 1, 1'b1);
        send(FSS_OP_SEC_RELEASE, 1'b0, 20'h0, 3'h0, 1, 1'b0);
        send(FSS_OP_SEC_SET, 1'b0, 20'h0, 3'h0, 1, 1'b1);
        enter;
        `CHK(sec_active, 3'h5)
        @(posedge core_clk) sig_req <= 1'b1;
        @(posedge core_clk) sig_req <= 1'b0;
        n = 0;
        #1;
        while (sig_valid !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            #1 n++;
        end
        for (int i = 0; i < 22; i++) begin
            `CHK(sig_byte, SIG_EXP[175 - 8 * i -: 8])
            `CHK({sig_valid, sig_last}, {1'b1, 1'(i == 21)})
            @(posedge core_clk);
            sig_req <= 1'(i == 4);
            #1;
        end
        repeat (3) begin
            `CHK(sig_valid, 1'b0)
            @(posedge core_clk);
            #1;
        end
        end_of_test;
    end

endmodule : tb
